//--- rtl/tlf_params.svh
/*
  Offsets, field positions, reset values, trip codes and timing counts
  of the trip log and fault response block.
  Assumes inclusion by bare name from the design file and the bench top.
*/
`ifndef TLF_PARAMS_SVH
`define TLF_PARAMS_SVH

// History depth and monitor count
`define TLF_HIST_N        10
`define TLF_MON_N         18

// Register byte addresses
`define TLF_REG_CTRL      8'h00
`define TLF_REG_STATUS    8'h04
`define TLF_REG_IRQ_STAT  8'h08
`define TLF_REG_IRQ_MASK  8'h0c
`define TLF_REG_FIRE_SPD  8'h10
`define TLF_REG_OVLD_TH   8'h14
`define TLF_REG_CODE_BASE 8'h40
`define TLF_REG_DATE_BASE 8'h80
`define TLF_REG_TIME_BASE 8'hc0

// Control fields
`define TLF_CTRL_TAG_SEL  0
`define TLF_CTRL_TSRC_LO  1
`define TLF_CTRL_RFC      3
`define TLF_CTRL_CLEAR    4

// Event bits, shared by status, irq status and irq mask
`define TLF_EV_TRIP       0
`define TLF_EV_FIRE       1
`define TLF_EV_BRAKE      2

// Reset values and overload threshold ceiling
`define TLF_CTRL_RST      32'h0000_0001
`define TLF_OVLD_OL_RST   8'h71
`define TLF_OVLD_RFC_RST  8'h72
`define TLF_OVLD_LIMIT    8'h96

// Trip codes
`define TLF_T_UNDERVOLT   8'h01
`define TLF_T_OVERVOLT    8'h02
`define TLF_T_BRAKE_OI    8'h03
`define TLF_T_BRAKE_OVL   8'h04
`define TLF_T_SUPPLY      8'h05
`define TLF_T_AUX_SUPPLY  8'h09
`define TLF_T_MOTOR_OVL   8'h14
`define TLF_T_MOTOR_THERM 8'h18
`define TLF_T_OUT_OVL     8'h1a
`define TLF_T_PROG_LO     8'h28
`define TLF_T_PROG_HI     8'h59
`define TLF_T_HWF_LO      8'hc8
`define TLF_T_HWF_HI      8'he8

// Warning flash half period
`define TLF_FLASH_MS      500
`define TLF_CLK_NS        10

`endif

//--- rtl/tlf_pkg.sv
/*
  Types of the trip log and fault response block.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package tlf_pkg;

  // Drive fault state, gray coded
  typedef enum logic [1:0] {
    TLF_RUN     = 2'b00,
    TLF_TRIPPED = 2'b01
  } tlf_state_t;

  // Logged time source
  typedef enum logic [1:0] {
    TLF_SRC_POWERUP = 2'b00,
    TLF_SRC_RUNTIME = 2'b01,
    TLF_SRC_RTC     = 2'b10
  } tlf_tsrc_t;

endpackage

//--- rtl/tlf_trip_unit.sv
/*
  Trip log and fault response: ten deep trip history with date/time or
  module tags, output disable, monitor freeze, fire mode trip filter,
  braking switch, user program and digital output gating, Avalon-MM
  register slave with sticky interrupt status.
  Assumes clk at 100 MHz, trip and pin inputs synchronous to clk.
*/
// Added by the designer: register access over Avalon-MM and the register offsets.
// Notes on behaviour
// - keep ten most recent trip codes
// - slot one newest or active, ten oldest
// - tag select: date+time, or module number
// - date and time copied at logging
// - selector picks power-up, running or clock time
// - history reads return numeric trip code
// - any trip disables power output stage
// - freeze monitors on trip except undervoltage
// - fire mode keeps restricted trip set only
// - I/O runs; overload/aux trips force outputs low
// - logic functions keep running while tripped
// - user program stops only on own trips
// - braking switch killed by listed trip classes
// - fire mode needs speed set and input four
// - fire mode disables motor overload, thermal protection
// - overload threshold 113/114 default, below 150
`timescale 1ns/1ps
`include "tlf_params.svh"

module tlf_trip_unit #(
  parameter int unsigned FLASH_CYC = `TLF_FLASH_MS * (1000000 / `TLF_CLK_NS)
) (
  // Clock and reset
  input  wire logic                        clk,
  input  wire logic                        rst_n,
  // Avalon-MM slave
  input  wire logic [7:0]                  avs_address,
  input  wire logic                        avs_read,
  input  wire logic                        avs_write,
  input  wire logic [3:0]                  avs_byteenable,
  input  wire logic [31:0]                 avs_writedata,
  output logic      [31:0]                 avs_readdata,
  output logic                             avs_waitrequest,
  output logic                             irq,
  // Trip sources and tag inputs
  input  wire logic                        trip_valid,
  input  wire logic [7:0]                  trip_code,
  input  wire logic [7:0]                  trip_module,
  input  wire logic [15:0]                 date_now,
  input  wire logic [15:0]                 time_powerup,
  input  wire logic [15:0]                 time_running,
  input  wire logic [15:0]                 time_rtc,
  input  wire logic [7:0]                  motor_current_pct,
  input  wire logic                        digital_in4,
  // Monitor values
  input  wire logic [`TLF_MON_N-1:0][15:0] monitor_in,
  output logic      [`TLF_MON_N-1:0][15:0] monitor_out,
  // Subsystem controls
  output logic                             output_stage_en,
  output logic                             dout_force_low,
  output logic                             logic_func_en,
  output logic                             user_prog_run,
  output logic                             brake_switch_en,
  output logic                             motor_prot_en,
  output logic                             fire_mode,
  output logic                             fire_warning
);

  // Trip classes
  function automatic logic is_brake_kill(input logic [7:0] c);
    is_brake_kill = (c == `TLF_T_BRAKE_OI) || (c == `TLF_T_SUPPLY) ||
                    (c == `TLF_T_BRAKE_OVL) || (c == `TLF_T_OVERVOLT) ||
                    (c >= `TLF_T_HWF_LO && c <= `TLF_T_HWF_HI);
  endfunction

  // Fire mode keeps only supply and hardware protection
  function automatic logic fire_allowed(input logic [7:0] c);
    fire_allowed = (c == `TLF_T_UNDERVOLT) || (c == `TLF_T_OVERVOLT) ||
                   (c == `TLF_T_SUPPLY) ||
                   (c >= `TLF_T_HWF_LO && c <= `TLF_T_HWF_HI);
  endfunction

  // Byte lane merge for writes
  function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] n,
                                        input logic [3:0] be);
    for (int b = 0; b < 4; b++) begin
      merge[b*8 +: 8] = be[b] ? n[b*8 +: 8] : o[b*8 +: 8];
    end
  endfunction

  // Reset release through two flops
  logic rst_meta, rst_sync_n;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_meta   <= 1'b0;
      rst_sync_n <= 1'b0;
    end else begin
      rst_meta   <= 1'b1;
      rst_sync_n <= rst_meta;
    end
  end

  // State
  tlf_pkg::tlf_state_t state;
  tlf_pkg::tlf_state_t next_state;
  logic [7:0]  hist_code [`TLF_HIST_N], next_hist_code [`TLF_HIST_N];
  logic [15:0] hist_date [`TLF_HIST_N], next_hist_date [`TLF_HIST_N];
  logic [15:0] hist_time [`TLF_HIST_N], next_hist_time [`TLF_HIST_N];
  logic        brake_dead, next_brake_dead;
  logic [31:0] ctrl, next_ctrl;
  logic [15:0] fire_speed, next_fire_speed;
  logic [7:0]  ovld_th, next_ovld_th;
  logic [2:0]  irq_stat, next_irq_stat;
  logic [2:0]  irq_mask, next_irq_mask;
  logic        ack, next_ack;
  logic [31:0] rdata, next_rdata;
  logic        fire_prev;
  logic [25:0] flash_cnt, next_flash_cnt;
  logic        blink, next_blink;
  // Decoded control
  logic        tag_sel, rfc_mode, wr_take, clear_req;
  logic [1:0]  tsrc;
  assign tag_sel   = ctrl[`TLF_CTRL_TAG_SEL];
  assign tsrc      = ctrl[`TLF_CTRL_TSRC_LO +: 2];
  assign rfc_mode  = ctrl[`TLF_CTRL_RFC];
  assign wr_take   = avs_write && ack; // Write lands at the edge that ends the wait
  assign clear_req = wr_take && avs_address == `TLF_REG_CTRL && avs_byteenable[0] &&
                     avs_writedata[`TLF_CTRL_CLEAR];

  // Fire mode entry and flashing warning
  assign fire_mode     = (fire_speed != 16'h0000) && digital_in4;
  assign fire_warning  = fire_mode && blink;
  assign motor_prot_en = !fire_mode;
  // Time source select
  logic [15:0] time_sel;
  always_comb begin
    case (tsrc)
      tlf_pkg::TLF_SRC_POWERUP: time_sel = time_powerup;
      tlf_pkg::TLF_SRC_RUNTIME: time_sel = time_running;
      tlf_pkg::TLF_SRC_RTC:     time_sel = time_rtc;
      default:                  time_sel = time_powerup;
    endcase
  end
  // Candidate trip; the overload comparator only fills idle cycles and re-fires while high
  logic       ovl_req, cand_valid, cand_en, accept;
  logic [7:0] cand_code;
  assign ovl_req    = motor_prot_en && (motor_current_pct >= ovld_th);
  assign cand_valid = trip_valid || ovl_req;
  assign cand_code  = trip_valid ? trip_code : `TLF_T_MOTOR_OVL;
  assign cand_en    = cand_valid && (!fire_mode || fire_allowed(cand_code));
  assign accept     = cand_en && state == tlf_pkg::TLF_RUN;

  // Fault state, history and brake latch
  always_comb begin
    next_state      = state;
    next_brake_dead = brake_dead;
    next_hist_code  = hist_code;
    next_hist_date  = hist_date;
    next_hist_time  = hist_time;
    if (clear_req) begin
      next_state      = tlf_pkg::TLF_RUN;
      next_brake_dead = 1'b0;
    end
    // Brake kill also counts trips masked by one already active
    if (cand_en && is_brake_kill(cand_code)) begin
      next_brake_dead = 1'b1;
    end
    if (accept) begin
      next_state = tlf_pkg::TLF_TRIPPED;
      for (int i = `TLF_HIST_N - 1; i > 0; i--) begin
        next_hist_code[i] = hist_code[i-1];
        next_hist_date[i] = hist_date[i-1];
        next_hist_time[i] = hist_time[i-1];
      end
      next_hist_code[0] = cand_code;
      next_hist_date[0] = tag_sel ? date_now : 16'h0000;
      next_hist_time[0] = tag_sel ? time_sel : {8'h00, trip_module};
    end
  end
  always_ff @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      state      <= tlf_pkg::TLF_RUN;
      brake_dead <= 1'b0;
      for (int i = 0; i < `TLF_HIST_N; i++) begin
        hist_code[i] <= 8'h00;
        hist_date[i] <= 16'h0000;
        hist_time[i] <= 16'h0000;
      end
    end else begin
      state      <= next_state;
      brake_dead <= next_brake_dead;
      hist_code  <= next_hist_code;
      hist_date  <= next_hist_date;
      hist_time  <= next_hist_time;
    end
  end

  // Subsystem gating from the active trip
  logic       tripped, freeze;
  logic [7:0] act_code;
  assign tripped         = state == tlf_pkg::TLF_TRIPPED;
  assign act_code        = hist_code[0];
  assign output_stage_en = !tripped;
  assign dout_force_low  = tripped && (act_code == `TLF_T_OUT_OVL ||
                                       act_code == `TLF_T_AUX_SUPPLY);
  assign logic_func_en   = 1'b1;
  assign user_prog_run   = !(tripped && act_code >= `TLF_T_PROG_LO &&
                             act_code <= `TLF_T_PROG_HI);
  assign brake_switch_en = !brake_dead;
  // Monitor freeze; undervoltage trips leave them live
  assign freeze = tripped && act_code != `TLF_T_UNDERVOLT;
  for (genvar m = 0; m < `TLF_MON_N; m++) begin : g_mon
    always_ff @(posedge clk or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
        monitor_out[m] <= 16'h0000;
      end else begin
        monitor_out[m] <= freeze ? monitor_out[m] : monitor_in[m];
      end
    end
  end

  // Flash timer for the fire warning
  always_comb begin
    next_flash_cnt = flash_cnt + 26'd1;
    next_blink     = blink;
    if (!fire_mode) begin
      next_flash_cnt = 26'd0;
      next_blink     = 1'b1;
    end else if (flash_cnt >= 26'(FLASH_CYC - 1)) begin
      next_flash_cnt = 26'd0;
      next_blink     = !blink;
    end
  end
  // Register file and bus answer; one wait state per access
  logic [3:0] slot;
  logic [2:0] events;
  assign slot   = avs_address[5:2];
  assign events = {cand_en && is_brake_kill(cand_code), fire_mode && !fire_prev, accept};
  always_comb begin
    next_ctrl       = ctrl;
    next_fire_speed = fire_speed;
    next_ovld_th    = ovld_th;
    next_irq_mask   = irq_mask;
    next_irq_stat   = irq_stat;
    next_ack        = (avs_read || avs_write) && !ack;
    next_rdata      = rdata;
    if (wr_take) begin
      case (avs_address)
        `TLF_REG_CTRL: begin
          next_ctrl = merge(ctrl, avs_writedata, avs_byteenable) & 32'h0000_000f;
          // Reset threshold follows the control mode when the mode changes
          if (next_ctrl[`TLF_CTRL_RFC] != rfc_mode) begin
            next_ovld_th = next_ctrl[`TLF_CTRL_RFC] ? `TLF_OVLD_RFC_RST : `TLF_OVLD_OL_RST;
          end
        end
        `TLF_REG_IRQ_STAT: begin
          if (avs_byteenable[0]) begin
            next_irq_stat = irq_stat & ~avs_writedata[2:0];
          end
        end
        `TLF_REG_IRQ_MASK: begin
          if (avs_byteenable[0]) begin
            next_irq_mask = avs_writedata[2:0];
          end
        end
        `TLF_REG_FIRE_SPD: next_fire_speed = 16'(merge({16'h0000, fire_speed}, avs_writedata, avs_byteenable));
        `TLF_REG_OVLD_TH: begin
          // Values at or above the ceiling are capped just below it
          if (avs_byteenable[0]) begin
            next_ovld_th = (avs_writedata[7:0] >= `TLF_OVLD_LIMIT) ?
                           `TLF_OVLD_LIMIT - 8'h01 : avs_writedata[7:0];
          end
        end
        default: ;
      endcase
    end
    next_irq_stat = next_irq_stat | events; // set wins over clear
    if (avs_read && !ack) begin
      next_rdata = 32'h0000_0000;
      case (avs_address)
        `TLF_REG_CTRL:     next_rdata = ctrl;
        `TLF_REG_STATUS:   next_rdata = {16'h0000, act_code, 5'h00,
                                         brake_switch_en, fire_mode, tripped};
        `TLF_REG_IRQ_STAT: next_rdata = {29'h0, irq_stat};
        `TLF_REG_IRQ_MASK: next_rdata = {29'h0, irq_mask};
        `TLF_REG_FIRE_SPD: next_rdata = {16'h0000, fire_speed};
        `TLF_REG_OVLD_TH:  next_rdata = {24'h0, ovld_th};
        default: begin
          if (slot < 4'(`TLF_HIST_N)) begin
            case (avs_address[7:6])
              2'b01:   next_rdata = {24'h0, hist_code[slot]};
              2'b10:   next_rdata = {16'h0000, hist_date[slot]};
              2'b11:   next_rdata = {16'h0000, hist_time[slot]};
              default: next_rdata = 32'h0000_0000;
            endcase
          end
        end
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      ctrl       <= `TLF_CTRL_RST;
      fire_speed <= 16'h0000;
      ovld_th    <= `TLF_OVLD_OL_RST;
      irq_stat   <= 3'h0;
      irq_mask   <= 3'h0;
      ack        <= 1'b0;
      rdata      <= 32'h0000_0000;
      fire_prev  <= 1'b0;
      flash_cnt  <= 26'd0;
      blink      <= 1'b1;
    end else begin
      ctrl       <= next_ctrl;
      fire_speed <= next_fire_speed;
      ovld_th    <= next_ovld_th;
      irq_stat   <= next_irq_stat;
      irq_mask   <= next_irq_mask;
      ack        <= next_ack;
      rdata      <= next_rdata;
      fire_prev  <= fire_mode;
      flash_cnt  <= next_flash_cnt;
      blink      <= next_blink;
    end
  end

  assign avs_waitrequest = (avs_read || avs_write) && !ack;
  assign avs_readdata    = rdata;
  assign irq             = |(irq_stat & irq_mask);

  // Checks
  a_trip_disables: assert property (@(posedge clk) disable iff (!rst_sync_n)
    accept && !clear_req |=> !output_stage_en) else $error("output stage not disabled");
  a_hist_shift: assert property (@(posedge clk) disable iff (!rst_sync_n)
    accept |=> hist_code[0] == $past(cand_code) && hist_code[9] == $past(hist_code[8]))
    else $error("history not shifted");
  a_tag_time: assert property (@(posedge clk) disable iff (!rst_sync_n)
    accept && tag_sel |=> hist_time[0] == $past(time_sel) && hist_date[0] == $past(date_now))
    else $error("date/time tag wrong");
  a_tag_module: assert property (@(posedge clk) disable iff (!rst_sync_n)
    accept && !tag_sel |=> hist_time[0] == {8'h00, $past(trip_module)})
    else $error("module tag wrong");
  a_mon_frozen: assert property (@(posedge clk) disable iff (!rst_sync_n)
    freeze && $past(freeze) |-> $stable(monitor_out)) else $error("monitor moved while frozen");
  a_fire_filter: assert property (@(posedge clk) disable iff (!rst_sync_n)
    fire_mode && trip_valid && !fire_allowed(trip_code) && !tripped && !clear_req
    |=> !tripped) else $error("trip taken in fire mode");
  a_dout_low: assert property (@(posedge clk) disable iff (!rst_sync_n)
    accept && cand_code == `TLF_T_AUX_SUPPLY && !clear_req |=> dout_force_low)
    else $error("digital outputs not forced low");
  a_prog_stop: assert property (@(posedge clk) disable iff (!rst_sync_n)
    user_prog_run != (tripped && act_code inside {[`TLF_T_PROG_LO:`TLF_T_PROG_HI]}))
    else $error("user program gating wrong");
  a_brake_kill: assert property (@(posedge clk) disable iff (!rst_sync_n)
    cand_en && is_brake_kill(cand_code) |=> !brake_switch_en) else $error("brake not killed");
  a_fire_prot: assert property (@(posedge clk) disable iff (!rst_sync_n)
    fire_mode && !trip_valid && !tripped |-> !motor_prot_en ##1 !tripped)
    else $error("protection active in fire mode");
  a_thresh_cap: assert property (@(posedge clk) disable iff (!rst_sync_n)
    ovld_th < `TLF_OVLD_LIMIT) else $error("overload threshold too high");
  a_bus_answer: assert property (@(posedge clk) disable iff (!rst_sync_n)
    $rose(avs_read) |=> !avs_waitrequest) else $error("bus answer late");

  c_trip_logged: cover property (@(posedge clk) disable iff (!rst_sync_n) accept);
  c_fire_trip:   cover property (@(posedge clk) disable iff (!rst_sync_n) fire_mode && accept);
  c_brake_kill:  cover property (@(posedge clk) disable iff (!rst_sync_n) $fell(brake_switch_en));
  c_clear:       cover property (@(posedge clk) disable iff (!rst_sync_n) tripped && clear_req);

endmodule

//--- testbench/tlf_host_model.sv
/*
  Host side model: Avalon-MM master that reads and writes the registers.
  Assumes a slave that answers on clk with waitrequest.
*/
`timescale 1ns/1ps

module tlf_host_model (
  // Clock
  input  wire logic        clk,
  // Avalon-MM master
  output logic [7:0]       avs_address,
  output logic             avs_read,
  output logic             avs_write,
  output logic [3:0]       avs_byteenable,
  output logic [31:0]      avs_writedata,
  input  wire logic [31:0] avs_readdata,
  input  wire logic        avs_waitrequest
);
  logic [31:0] rd_data;
  logic        tmo;
  event        rd_ev;

  // Idle bus at time zero
  initial begin
    avs_address = 8'h00;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_byteenable = 4'h0;
    avs_writedata = 32'h0;
    tmo = 1'b0;
  end

  // One access, held until waitrequest is seen low at a rising edge
  task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int   n;
    logic done;
    n = 0;
    @(posedge clk);
    avs_address <= a;
    avs_writedata <= d;
    avs_byteenable <= 4'hf;
    if (wr) begin
      avs_write <= 1'b1;
    end else begin
      avs_read <= 1'b1;
    end
    // Waitrequest and read data are taken at the rising edge itself
    do begin
      @(posedge clk);
      done = (avs_waitrequest === 1'b0);
      rd_data = avs_readdata;
      n++;
    end while (!done && n < 64);
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    avs_writedata <= ~d; // Released data must not look valid
    if (!done) begin
      tmo = 1'b1;
    end else if (!wr) begin
      -> rd_ev;
    end
  endtask
endmodule

//--- testbench/tlf_trip_unit_tb_top.sv
/*
  Self-checking bench of the trip unit: history, tags, trip responses,
  interrupt, fire mode and overload threshold.
  Assumes tlf_host_model as register master.
*/
`timescale 1ns/1ps
`include "tlf_params.svh"

module tlf_trip_unit_tb_top;
  typedef struct packed { logic [7:0] a; logic [31:0] v; } tlf_note_t;
  logic                        clk, rst_n, trip_valid, digital_in4, irq, avs_read, avs_write;
  logic                        avs_waitrequest, output_stage_en, dout_force_low;
  logic                        logic_func_en, user_prog_run, brake_switch_en;
  logic                        motor_prot_en, fire_mode, fire_warning;
  logic [3:0]                  avs_byteenable;
  logic [7:0]                  avs_address, trip_code, trip_module, motor_current_pct;
  logic [15:0]                 date_now, time_powerup, time_running, time_rtc;
  logic [31:0]                 avs_writedata, avs_readdata, ctrl;
  logic [`TLF_MON_N-1:0][15:0] monitor_in, monitor_out, a_mon;
  logic [15:0]                 e_code [10], e_date [10], e_time [10];
  logic [7:0]                  codes [11];
  logic [1:0]                  seen;
  tlf_note_t                   exp_q [$];
  tlf_note_t                   note;
  int                          n_errors, check_count;

  tlf_trip_unit #(.FLASH_CYC(4)) u_tlf_trip_unit (
    .clk(clk), .rst_n(rst_n), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_byteenable(avs_byteenable), .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .irq(irq),
    .trip_valid(trip_valid), .trip_code(trip_code), .trip_module(trip_module),
    .date_now(date_now), .time_powerup(time_powerup), .time_running(time_running),
    .time_rtc(time_rtc), .motor_current_pct(motor_current_pct), .digital_in4(digital_in4),
    .monitor_in(monitor_in), .monitor_out(monitor_out), .output_stage_en(output_stage_en),
    .dout_force_low(dout_force_low), .logic_func_en(logic_func_en),
    .user_prog_run(user_prog_run), .brake_switch_en(brake_switch_en),
    .motor_prot_en(motor_prot_en), .fire_mode(fire_mode), .fire_warning(fire_warning));

  tlf_host_model u_tlf_host_model (
    .clk(clk), .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_byteenable(avs_byteenable), .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest));

  task automatic end_of_test;
    $display("checks %0d errors %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [287:0] e, input logic [287:0] g);
    check_count++;
    if (g !== e) begin
      n_errors++;
      $display("MISMATCH %s expected %0h seen %0h", nm, e, g);
    end
  endtask

  // Read with the expected word noted first, compared by the watcher
  task automatic rchk(input logic [7:0] a, input logic [31:0] v);
    exp_q.push_back('{a, v});
    u_tlf_host_model.xfer(1'b0, a, 32'h0);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    u_tlf_host_model.xfer(1'b1, a, v);
  endtask

  // Wait edges, then step past them so outputs have landed
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic new_vals;
    @(posedge clk);
    date_now <= 16'($urandom);
    time_powerup <= 16'($urandom);
    time_running <= 16'($urandom);
    time_rtc <= 16'($urandom);
    for (int m = 0; m < `TLF_MON_N; m++) monitor_in[m] <= 16'($urandom);
  endtask

  task automatic trip(input logic [7:0] c);
    @(posedge clk);
    trip_valid <= 1'b1;
    trip_code <= c;
    trip_module <= 8'($urandom);
    @(posedge clk);
    trip_valid <= 1'b0;
    tick(2);
  endtask

  function automatic logic brk_kill(input logic [7:0] c);
    return (c inside {8'h02, 8'h03, 8'h04, 8'h05}) || (c >= 8'hc8 && c <= 8'he8);
  endfunction

  // Watcher: oldest note against each completed read
  always @(u_tlf_host_model.rd_ev) begin
    if (exp_q.size() == 0) begin
      n_errors++;
      $display("MISMATCH read note expected 1 seen 0");
    end else begin
      note = exp_q.pop_front();
      chk($sformatf("reg %h", note.a), note.v, u_tlf_host_model.rd_data);
    end
  end

  // Hang guards end the run through the same report
  always @(posedge u_tlf_host_model.tmo) begin
    n_errors++;
    end_of_test();
  end
  initial begin
    #500us;
    n_errors++;
    end_of_test();
  end

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  initial begin
    {rst_n, trip_valid, digital_in4, trip_code, trip_module, motor_current_pct} = '0;
    {date_now, time_powerup, time_running, time_rtc, monitor_in} = '0;
    n_errors = 0;
    check_count = 0;
    codes = '{8'h01, 8'h02, 8'h03, 8'h04, 8'h05, 8'h09, 8'h1a, 8'h28, 8'h59, 8'hc8, 8'he8};
    void'($urandom(32'h0faf));
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
    rchk(`TLF_REG_CTRL, 32'h1);
    rchk(8'h3c, 32'h0);
    rchk(`TLF_REG_STATUS, 32'h4);
    // Eleven trips: the first falls out of the ten-deep history
    for (int i = 0; i < 11; i++) begin
      ctrl = {29'h0, 2'(i % 3), 1'(i % 4 != 3)};
      new_vals();
      wr(`TLF_REG_CTRL, ctrl);
      tick(2);
      a_mon = monitor_in;
      trip(codes[i]);
      for (int k = 9; k > 0; k--) begin
        e_code[k] = e_code[k-1];
        e_date[k] = e_date[k-1];
        e_time[k] = e_time[k-1];
      end
      e_code[0] = {8'h0, codes[i]};
      e_date[0] = ctrl[0] ? date_now : 16'h0;
      e_time[0] = !ctrl[0] ? {8'h0, trip_module} : ctrl[2:1] == 2'd0 ? time_powerup :
                  ctrl[2:1] == 2'd1 ? time_running : time_rtc;
      chk("output_stage_en", 1'b0, output_stage_en);
      chk("dout_force_low", codes[i] inside {8'h1a, 8'h09}, dout_force_low);
      chk("user_prog_run", !(codes[i] inside {[8'h28:8'h59]}), user_prog_run);
      chk("brake_switch_en", !brk_kill(codes[i]), brake_switch_en);
      chk("logic_func_en", 1'b1, logic_func_en);
      new_vals();
      tick(3);
      chk("monitor_out", codes[i] == 8'h01 ? monitor_in : a_mon, monitor_out);
      if (i == 0) begin
        rchk(`TLF_REG_IRQ_STAT, 32'h1);
        chk("irq", 1'b0, irq);
        wr(`TLF_REG_IRQ_MASK, 32'h1);
        tick(1);
        chk("irq", 1'b1, irq);
        wr(`TLF_REG_IRQ_STAT, 32'h1);
        tick(1);
        chk("irq", 1'b0, irq);
      end
      if (codes[i] == 8'h1a) begin
        trip(8'h03);
        chk("brake_switch_en", 1'b0, brake_switch_en);
      end
      wr(`TLF_REG_CTRL, ctrl | 32'h10);
      tick(2);
      chk("output_stage_en", 1'b1, output_stage_en);
    end
    for (int k = 0; k < 10; k++) begin
      rchk(`TLF_REG_CODE_BASE + 8'(4 * k), {16'h0, e_code[k]});
      rchk(`TLF_REG_DATE_BASE + 8'(4 * k), {16'h0, e_date[k]});
      rchk(`TLF_REG_TIME_BASE + 8'(4 * k), {16'h0, e_time[k]});
    end
    // Fire mode needs both a speed and the input
    wr(`TLF_REG_FIRE_SPD, 32'h0);
    @(posedge clk);
    digital_in4 <= 1'b1;
    tick(3);
    chk("fire_mode", 1'b0, fire_mode);
    wr(`TLF_REG_FIRE_SPD, 32'h0100);
    tick(3);
    chk("fire_mode", 1'b1, fire_mode);
    chk("motor_prot_en", 1'b0, motor_prot_en);
    seen = 2'b00;
    repeat (12) begin
      tick(1);
      if (fire_warning === 1'b1) seen[1] = 1'b1;
      if (fire_warning === 1'b0) seen[0] = 1'b1;
    end
    chk("fire_warning", 2'b11, seen);
    @(posedge clk);
    motor_current_pct <= 8'hff;
    trip(8'h1a);
    chk("output_stage_en", 1'b1, output_stage_en);
    trip(8'h02);
    chk("output_stage_en", 1'b0, output_stage_en);
    @(posedge clk);
    digital_in4 <= 1'b0;
    motor_current_pct <= 8'h00;
    wr(`TLF_REG_CTRL, 32'h11);
    tick(3);
    chk("fire_mode", 1'b0, fire_mode);
    // Overload threshold defaults, limit and trip point
    rchk(`TLF_REG_OVLD_TH, 32'h71);
    wr(`TLF_REG_CTRL, 32'h9);
    rchk(`TLF_REG_OVLD_TH, 32'h72);
    wr(`TLF_REG_OVLD_TH, 32'hc8);
    rchk(`TLF_REG_OVLD_TH, 32'h95);
    @(posedge clk);
    motor_current_pct <= 8'h94;
    tick(3);
    chk("output_stage_en", 1'b1, output_stage_en);
    @(posedge clk);
    motor_current_pct <= 8'h95;
    tick(3);
    chk("output_stage_en", 1'b0, output_stage_en);
    rchk(`TLF_REG_CODE_BASE, 32'h14);
    tick(2);
    chk("pending notes", 0, exp_q.size());
    end_of_test();
  end
endmodule
